/* verilog/flash_ctrl_consts.svh */
// offsets, field positions, reset values and timing counts of the flash controller
// included by the package and the controller; definitions only
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH

`define REG_STATUS 1'h0
`define REG_CTRL 1'h1

`define FLASH_LAST 16'h4fff
`define NUM_SECT 5
`define SECT_LSB 12
`define SECT_MSB 14

`define CTRL_PAGE_LSB 0
`define CTRL_PAGE_MSB 19
`define CTRL_SECT_LSB 20
`define CTRL_SECT_MSB 22
`define CTRL_WP_LSB 23
`define CTRL_WP_MSB 27
`define CTRL_PAGE_NONE 20'hfffff
`define CTRL_LOC_RESET 23'h0fffff
`define CTRL_WP_RESET 5'h1f

`define BUSY_IDLE 2'h0
`define BUSY_ERASE 2'h1
`define BUSY_PROG 2'h2
`define BUSY_READ 2'h3

`define BLANK_WORD 32'hffffffff
`define SERIAL_BEATS 8'h20
`define MAX_BURST 8'h80
`define WRAP_SMALL 8'h02
`define WRAP_LARGE 8'h04

`define ERASE_MAX_MS 350
`define CLK_KHZ 100000
`define ERASE_MAX_CYC (`ERASE_MAX_MS * `CLK_KHZ)

`endif

/* verilog/flash_ctrl_pkg.sv */
// types shared by the flash controller
// assumes nothing beyond the constants header
`include "flash_ctrl_consts.svh"

package flash_ctrl_pkg;
    typedef enum logic [2:0] {
        st_idle,
        st_erase,
        st_prog,
        st_wr_collect,
        st_rd_fetch,
        st_rd_data,
        st_rd_shift
    } fsm_state_t;
    typedef logic [1:0] busy_t;
endpackage

/* verilog/user_flash_erase_read_ctrl.sv */
// user flash controller: erase via control port, reads and program via data port
// assumes a flash array that answers a read one cycle after arr_read_out and
// signals erase and program completion with done/ok inputs
// How it works
// - control write latches sector, starts erase
// - sector erase accepted only when idle
// - page erase accepted only when idle
// - busy shows 01 during erase
// - data requests stalled during erase
// - erase result from array recorded
// - erase up to 350 ms covered
// - bad sector or protected fails erase
// - illegal page address fails erase
// - waitrequest high while busy, except during serial program beat collection
// - readdatavalid marks every returned word
// - busy shows 11 during reads
// - read success flag, blank on failure
// - incrementing bursts up to 128 words
// - wrap burst count fixed 2 or 4
// - wrap past flash end restarts at zero
// - bad burst read clears read success flag
// - busy shows 10 during program
// - two-beat wrap returns to 64-bit boundary
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_consts.svh"

module user_flash_erase_read_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int ERASE_MAX_CYCLES = `ERASE_MAX_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [0:0] ctrl_addr_in,
    input wire logic [31:0] ctrl_wdata_in,
    input wire logic ctrl_write_in,
    input wire logic ctrl_read_in,
    output logic [31:0] ctrl_rdata_out,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [15:0] address_in,
    input wire logic [7:0] burstcount_in,
    input wire logic [31:0] writedata_in,
    output logic waitrequest_out,
    output logic [31:0] readdata_out,
    output logic readdatavalid_out,
    input wire logic serial_mode_in,
    input wire logic wrap_mode_in,
    input wire logic wide_wrap_in,
    input wire logic [4:0] sect_protect_in,
    output logic [15:0] arr_addr_out,
    output logic arr_read_out,
    input wire logic [31:0] arr_rdata_in,
    output logic arr_prog_out,
    output logic [31:0] arr_wdata_out,
    input wire logic arr_prog_done_in,
    input wire logic arr_prog_ok_in,
    output logic arr_erase_out,
    output logic arr_erase_page_out,
    input wire logic arr_erase_done_in,
    input wire logic arr_erase_ok_in
);
    fsm_state_t state_reg, state_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0] beats_reg, beats_next;
    logic [31:0] shift_reg, shift_next;
    logic [25:0] erase_cnt_reg, erase_cnt_next;
    logic serial_reg, serial_next, wrap_reg, wrap_next, wide_reg, wide_next;
    logic bad_reg, bad_next, page_op_reg, page_op_next;
    logic [4:0] wp_reg;
    logic [22:0] erase_loc_reg;
    logic rd_ok_reg, rd_ok_next, wr_ok_reg, wr_ok_next;
    logic er_ok_reg, er_ok_next, empty_reg, empty_next;
    logic [31:0] readdata_next;
    logic readdatavalid_next;
    logic [7:0] rd_block, wr_clear;

    // per-sector read block and write-clear flags, padded so any 3-bit index is safe
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_sect
            if (i < `NUM_SECT) begin : g_real
                assign rd_block[i] = sect_protect_in[i];
                assign wr_clear[i] = !sect_protect_in[i] && !wp_reg[i];
            end else begin : g_pad
                assign rd_block[i] = 1'b1;
                assign wr_clear[i] = 1'b0;
            end
        end
    endgenerate

    wire ctrl_wr_hit = ctrl_write_in && (ctrl_addr_in == `REG_CTRL);
    wire [2:0] sect_code = ctrl_wdata_in[`CTRL_SECT_MSB:`CTRL_SECT_LSB];
    wire [19:0] page_field = ctrl_wdata_in[`CTRL_PAGE_MSB:`CTRL_PAGE_LSB];
    wire [2:0] sect_idx = sect_code - 3'h1;
    wire sect_legal = (sect_code != 3'h0) && (sect_code <= 3'(`NUM_SECT));
    wire sect_ok = sect_legal && wr_clear[sect_idx];
    wire page_legal = page_field <= {4'h0, `FLASH_LAST};
    wire sect_op = sect_code != 3'h0;
    // data port wins a tie with an erase write: waitrequest was already low
    wire data_req = (read_in || write_in) && (state_reg == st_idle);
    wire erase_req = ctrl_wr_hit && (state_reg == st_idle) && !data_req &&
                     (sect_op || (page_field != `CTRL_PAGE_NONE));
    wire erase_good = sect_op ? sect_ok : page_legal;

    wire [2:0] req_sect = address_in[`SECT_MSB:`SECT_LSB];
    wire [7:0] wrap_count = wide_wrap_in ? `WRAP_LARGE : `WRAP_SMALL;
    wire rd_burst_ok = serial_mode_in ? (burstcount_in == `SERIAL_BEATS) :
                       wrap_mode_in ? (burstcount_in == wrap_count) :
                       (burstcount_in != 8'h00) && (burstcount_in <= `MAX_BURST);
    wire wr_burst_ok = burstcount_in == (serial_mode_in ? `SERIAL_BEATS : 8'h01);
    wire wr_good = wr_burst_ok && (address_in <= `FLASH_LAST) && wr_clear[req_sect];

    wire beat_good = (addr_reg <= `FLASH_LAST) && !rd_block[addr_reg[`SECT_MSB:`SECT_LSB]];
    wire [31:0] beat_word = beat_good ? arr_rdata_in : `BLANK_WORD;
    wire [15:0] wrap_mask = wide_reg ? 16'h0003 : 16'h0001;
    wire [15:0] addr_inc = addr_reg + 16'h0001;
    wire [15:0] addr_wrapped = (addr_reg & ~wrap_mask) | (addr_inc & wrap_mask);
    // wrapping never leaves the flash: past the end it restarts at word zero
    wire [15:0] addr_step = !wrap_reg ? addr_inc :
                            (addr_wrapped > `FLASH_LAST) ? 16'h0000 : addr_wrapped;
    wire erase_timeout = erase_cnt_reg == 26'(ERASE_MAX_CYCLES - 1);

    busy_t busy;
    assign busy = (state_reg == st_erase) ? `BUSY_ERASE :
                  (state_reg == st_prog || state_reg == st_wr_collect) ? `BUSY_PROG :
                  (state_reg == st_idle) ? `BUSY_IDLE : `BUSY_READ;
    wire [31:0] status_word = {21'h0, sect_protect_in, empty_reg, er_ok_reg,
                               wr_ok_reg, rd_ok_reg, busy};
    wire [31:0] ctrl_word = {4'h0, wp_reg, erase_loc_reg};

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        beats_next = beats_reg;
        shift_next = shift_reg;
        erase_cnt_next = erase_cnt_reg;
        serial_next = serial_reg;
        wrap_next = wrap_reg;
        wide_next = wide_reg;
        bad_next = bad_reg;
        page_op_next = page_op_reg;
        rd_ok_next = rd_ok_reg;
        wr_ok_next = wr_ok_reg;
        er_ok_next = er_ok_reg;
        empty_next = empty_reg;
        readdata_next = 32'h0;
        readdatavalid_next = 1'b0;
        unique case (state_reg)
            st_idle: begin
                if (data_req && read_in) begin
                    state_next = st_rd_fetch;
                    addr_next = address_in;
                    serial_next = serial_mode_in;
                    wrap_next = wrap_mode_in && !serial_mode_in;
                    wide_next = wide_wrap_in;
                    beats_next = serial_mode_in ? `SERIAL_BEATS :
                                 rd_burst_ok ? burstcount_in : 8'h01;
                    rd_ok_next = rd_burst_ok;
                    empty_next = 1'b0;
                end else if (data_req) begin
                    addr_next = address_in;
                    bad_next = !wr_good;
                    if (serial_mode_in && wr_good) begin
                        state_next = st_wr_collect;
                        shift_next = {31'h0, writedata_in[0]};
                        beats_next = `SERIAL_BEATS - 8'h01;
                    end else begin
                        state_next = st_prog;
                        shift_next = writedata_in;
                    end
                end else if (erase_req) begin
                    state_next = st_erase;
                    bad_next = !erase_good;
                    page_op_next = !sect_op;
                    erase_cnt_next = 26'h0;
                    addr_next = sect_op ? {1'b0, sect_idx, 12'h000} : page_field[15:0];
                end
            end
            st_erase: begin
                erase_cnt_next = erase_cnt_reg + 26'h1;
                // held here one cycle if bad, else until the array answers or the 350 ms budget runs out
                if (bad_reg || arr_erase_done_in || erase_timeout) begin
                    state_next = st_idle;
                    er_ok_next = !bad_reg && arr_erase_done_in && arr_erase_ok_in;
                end
            end
            st_wr_collect: begin
                if (write_in) begin
                    shift_next = {shift_reg[30:0], writedata_in[0]};
                    beats_next = beats_reg - 8'h01;
                    if (beats_reg == 8'h01) begin
                        state_next = st_prog;
                    end
                end
            end
            st_prog: begin
                if (bad_reg || arr_prog_done_in) begin
                    state_next = st_idle;
                    wr_ok_next = !bad_reg && arr_prog_ok_in;
                end
            end
            st_rd_fetch: begin
                state_next = st_rd_data;
            end
            st_rd_data: begin
                rd_ok_next = rd_ok_reg && beat_good;
                empty_next = empty_reg || !beat_good;
                if (serial_reg) begin
                    shift_next = beat_word;
                    state_next = st_rd_shift;
                end else begin
                    readdata_next = beat_word;
                    readdatavalid_next = 1'b1;
                    beats_next = beats_reg - 8'h01;
                    addr_next = addr_step;
                    state_next = (beats_reg == 8'h01) ? st_idle : st_rd_fetch;
                end
            end
            st_rd_shift: begin
                readdata_next = {31'h0, shift_reg[31]};
                readdatavalid_next = 1'b1;
                shift_next = {shift_reg[30:0], 1'b0};
                beats_next = beats_reg - 8'h01;
                if (beats_reg == 8'h01) begin
                    state_next = st_idle;
                end
            end
        endcase
    end

    wire entering = state_next != state_reg;
    // stalls cover every busy state except the serial program beat collection
    wire wait_next = !(state_next == st_idle || state_next == st_wr_collect);

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= st_idle;
            addr_reg <= 16'h0;
            beats_reg <= 8'h0;
            shift_reg <= 32'h0;
            erase_cnt_reg <= 26'h0;
            serial_reg <= 1'b0;
            wrap_reg <= 1'b0;
            wide_reg <= 1'b0;
            bad_reg <= 1'b0;
            page_op_reg <= 1'b0;
            rd_ok_reg <= 1'b0;
            wr_ok_reg <= 1'b0;
            er_ok_reg <= 1'b0;
            empty_reg <= 1'b0;
            wp_reg <= `CTRL_WP_RESET;
            erase_loc_reg <= `CTRL_LOC_RESET;
            ctrl_rdata_out <= 32'h0;
            waitrequest_out <= 1'b1;
            readdata_out <= 32'h0;
            readdatavalid_out <= 1'b0;
            arr_addr_out <= 16'h0;
            arr_read_out <= 1'b0;
            arr_prog_out <= 1'b0;
            arr_wdata_out <= 32'h0;
            arr_erase_out <= 1'b0;
            arr_erase_page_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            beats_reg <= beats_next;
            shift_reg <= shift_next;
            erase_cnt_reg <= erase_cnt_next;
            serial_reg <= serial_next;
            wrap_reg <= wrap_next;
            wide_reg <= wide_next;
            bad_reg <= bad_next;
            page_op_reg <= page_op_next;
            rd_ok_reg <= rd_ok_next;
            wr_ok_reg <= wr_ok_next;
            er_ok_reg <= er_ok_next;
            empty_reg <= empty_next;
            if (ctrl_wr_hit) begin
                wp_reg <= ctrl_wdata_in[`CTRL_WP_MSB:`CTRL_WP_LSB];
            end
            if (erase_req) begin
                erase_loc_reg <= ctrl_wdata_in[22:0];
            end
            ctrl_rdata_out <= !ctrl_read_in ? 32'h0 :
                              (ctrl_addr_in == `REG_STATUS) ? status_word : ctrl_word;
            waitrequest_out <= wait_next;
            readdata_out <= readdata_next;
            readdatavalid_out <= readdatavalid_next;
            arr_addr_out <= addr_next;
            arr_read_out <= state_next == st_rd_fetch;
            arr_prog_out <= entering && (state_next == st_prog) && !bad_next;
            arr_wdata_out <= shift_next;
            arr_erase_out <= entering && (state_next == st_erase) && !bad_next;
            arr_erase_page_out <= page_op_next;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence erase_accept_s;
        erase_req && erase_good;
    endsequence
    sequence erase_running_s;
        ##1 (busy == `BUSY_ERASE) && waitrequest_out;
    endsequence

    erase_start_a: assert property (erase_accept_s |-> erase_running_s ##0 arr_erase_out)
        else $error("accepted erase did not start");
    // an erase finishing in the same cycle may still update its own result
    erase_ignore_a: assert property (ctrl_wr_hit && state_reg != st_idle
                                     |=> !arr_erase_out && $stable(erase_loc_reg) &&
                                     ($stable(er_ok_reg) || $past(state_next) == st_idle))
        else $error("erase written while busy was not ignored");
    erase_busy_a: assert property (ctrl_read_in && ctrl_addr_in == `REG_STATUS &&
                                   state_reg == st_erase |=> ctrl_rdata_out[1:0] == `BUSY_ERASE)
        else $error("busy field not erase during erase");
    erase_stall_a: assert property (state_reg == st_erase |-> waitrequest_out)
        else $error("data port not stalled during erase");
    erase_record_a: assert property (state_reg == st_erase && !bad_reg
                                     && arr_erase_done_in
                                     |=> er_ok_reg == $past(arr_erase_ok_in) && state_reg == st_idle)
        else $error("erase result not recorded");
    sector_fail_a: assert property (erase_req && sect_op && !sect_ok |-> ##2 !er_ok_reg
                                    && !arr_erase_out)
        else $error("bad sector erase not failed");
    page_fail_a: assert property (erase_req && !sect_op && !page_legal
                                  |-> ##2 !er_ok_reg)
        else $error("illegal page erase not failed");
    read_answer_a: assert property (data_req && read_in && !serial_mode_in
                                    |=> waitrequest_out ##2 readdatavalid_out)
        else $error("read not answered in three cycles");
    read_busy_a: assert property (ctrl_read_in && ctrl_addr_in == `REG_STATUS &&
                                  state_reg inside {st_rd_fetch, st_rd_data, st_rd_shift}
                                  |=> ctrl_rdata_out[1:0] == `BUSY_READ)
        else $error("busy field not read during read");
    blank_read_a: assert property (state_reg == st_rd_data && !serial_reg && !beat_good
                                   |=> readdata_out == `BLANK_WORD && empty_reg && !rd_ok_reg)
        else $error("failed read not blank and flagged");
    wrap_two_a: assert property (state_reg == st_rd_data && wrap_reg && !wide_reg &&
                                 beats_reg != 8'h01 |=> addr_reg == ($past(addr_reg) ^ 16'h0001))
        else $error("two-beat wrap left its boundary");
    serial_msb_a: assert property (state_reg == st_rd_data && serial_reg
                                   |-> ##2 readdata_out[0] == $past(beat_word[31], 2))
        else $error("serial read not msb first");
    prog_busy_a: assert property (ctrl_read_in && ctrl_addr_in == `REG_STATUS &&
                                  (state_reg == st_prog || state_reg == st_wr_collect)
                                  |=> ctrl_rdata_out[1:0] == `BUSY_PROG)
        else $error("busy field not program during program");

endmodule
`default_nettype wire

/* dv/flash_array_model.sv */
// flash array stand-in: answers a read one cycle late, finishes an erase after a delay
// assumes the controller drives registered one-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
    parameter int ERASE_DELAY = 20
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [15:0] addr_in,
    input wire logic read_in,
    input wire logic erase_in,
    input wire logic prog_in,
    output logic [31:0] rdata_out,
    output logic erase_done_out,
    output logic prog_done_out,
    output logic [7:0] erase_cnt_out
);
    logic rd_reg;
    logic [15:0] addr_reg;
    logic [31:0] last_reg;
    logic [7:0] cnt_reg;
    // outside a read the data lines flip, so a sample one cycle late never matches by luck
    assign rdata_out = rd_reg ? {~addr_reg, addr_reg} : ~last_reg;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_reg <= 1'b0;
            addr_reg <= 16'h0;
            last_reg <= 32'h0;
            cnt_reg <= 8'h0;
            erase_done_out <= 1'b0;
            prog_done_out <= 1'b0;
            erase_cnt_out <= 8'h0;
        end else begin
            rd_reg <= read_in;
            addr_reg <= addr_in;
            last_reg <= rdata_out;
            prog_done_out <= prog_in;
            // erase always ends well inside the controller's limit
            erase_done_out <= (cnt_reg == 8'h1);
            if (erase_in) begin
                cnt_reg <= 8'(ERASE_DELAY);
                erase_cnt_out <= erase_cnt_out + 8'h1;
            end else if (cnt_reg != 8'h0) begin
                cnt_reg <= cnt_reg - 8'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* dv/user_flash_erase_read_ctrl_tb.sv */
// self-checking bench for the flash controller: erases over the control port, reads on data port
// assumes the array model answers reads one cycle late and erases in 20 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module user_flash_erase_read_ctrl_tb;
    import flash_ctrl_pkg::*;
    logic ref_clk_in, rst_in, ctrl_write_in, ctrl_read_in, read_in, serial_mode_in;
    logic wrap_mode_in, wide_wrap_in, waitrequest_out, readdatavalid_out, arr_read_out;
    logic arr_prog_out, arr_erase_out, erase_done, prog_done, write_in, erase_page;
    logic [0:0] ctrl_addr_in;
    logic [31:0] ctrl_wdata_in, ctrl_rdata_out, readdata_out, arr_rdata, st;
    logic [31:0] writedata_in, prog_data;
    logic [15:0] address_in, arr_addr_out;
    logic [7:0] burstcount_in, erase_cnt;
    logic [4:0] sect_protect_in;
    logic [31:0] got[$];
    int miscompares = 0;
    int compares = 0;
    user_flash_erase_read_ctrl #(.ERASE_MAX_CYCLES(50)) uut (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .ctrl_addr_in(ctrl_addr_in), .ctrl_wdata_in(ctrl_wdata_in),
        .ctrl_write_in(ctrl_write_in), .ctrl_read_in(ctrl_read_in),
        .ctrl_rdata_out(ctrl_rdata_out), .read_in(read_in), .write_in(write_in),
        .address_in(address_in), .burstcount_in(burstcount_in), .writedata_in(writedata_in),
        .waitrequest_out(waitrequest_out), .readdata_out(readdata_out),
        .readdatavalid_out(readdatavalid_out), .serial_mode_in(serial_mode_in),
        .wrap_mode_in(wrap_mode_in), .wide_wrap_in(wide_wrap_in),
        .sect_protect_in(sect_protect_in), .arr_addr_out(arr_addr_out),
        .arr_read_out(arr_read_out), .arr_rdata_in(arr_rdata), .arr_prog_out(arr_prog_out),
        .arr_wdata_out(prog_data), .arr_prog_done_in(prog_done), .arr_prog_ok_in(prog_done),
        .arr_erase_out(arr_erase_out), .arr_erase_page_out(erase_page),
        .arr_erase_done_in(erase_done), .arr_erase_ok_in(erase_done));
    flash_array_model #(.ERASE_DELAY(20)) array_i (.clk_in(ref_clk_in), .rst_in(rst_in),
        .addr_in(arr_addr_out), .read_in(arr_read_out), .erase_in(arr_erase_out),
        .prog_in(arr_prog_out), .rdata_out(arr_rdata), .erase_done_out(erase_done),
        .prog_done_out(prog_done), .erase_cnt_out(erase_cnt));
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    function automatic logic [31:0] fdata(input logic [15:0] a);
        return {~a, a};
    endfunction
    task automatic ctrl_wr(input logic [31:0] d);
        @(posedge ref_clk_in);
        ctrl_addr_in <= 1'b1;
        ctrl_wdata_in <= d;
        ctrl_write_in <= 1'b1;
        @(posedge ref_clk_in);
        ctrl_write_in <= 1'b0;
    endtask
    task automatic status_rd();
        @(posedge ref_clk_in);
        ctrl_addr_in <= 1'b0;
        ctrl_read_in <= 1'b1;
        @(posedge ref_clk_in);
        ctrl_read_in <= 1'b0;
        @(posedge ref_clk_in);
        st = ctrl_rdata_out;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            status_rd();
            if (st[1:0] === 2'b00) break;
        end
    endtask
    // request held until waitrequest is seen low at an edge, then beats collected
    task automatic data_rd(input logic [15:0] a, input logic [7:0] bc, input int n);
        got.delete();
        @(posedge ref_clk_in);
        read_in <= 1'b1;
        address_in <= a;
        burstcount_in <= bc;
        for (int i = 0; i < 60; i++) begin
            @(posedge ref_clk_in);
            if (waitrequest_out === 1'b0) break;
        end
        read_in <= 1'b0;
        for (int i = 0; i < 400 && got.size() < n; i++) begin
            @(posedge ref_clk_in);
            if (readdatavalid_out === 1'b1) got.push_back(readdata_out);
        end
        `CHECK(got.size(), n)
    endtask
    // single parallel program, request held until taken
    task automatic data_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        write_in <= 1'b1;
        address_in <= a;
        burstcount_in <= 8'h1;
        writedata_in <= d;
        for (int i = 0; i < 60; i++) begin
            @(posedge ref_clk_in);
            if (waitrequest_out === 1'b0) break;
        end
        write_in <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        miscompares++;
        report_and_stop();
    end
    initial begin
        logic [15:0] wa[3];
        logic [2:0] wn[3];
        logic [15:0] b;
        logic [31:0] w;
        wa = '{16'h0001, 16'h0002, 16'h4fff};
        wn = '{3'd2, 3'd4, 3'd2};
        rst_in = 1'b1;
        {write_in, ctrl_write_in, ctrl_read_in, read_in, serial_mode_in, wrap_mode_in} = 6'h0;
        writedata_in = 32'h0;
        wide_wrap_in = 1'b0;
        ctrl_addr_in = 1'b0;
        ctrl_wdata_in = 32'h0;
        address_in = 16'h0;
        burstcount_in = 8'h1;
        sect_protect_in = 5'h00;
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        status_rd();
        `CHECK(st, 32'h0)
        ctrl_wr(32'h000f_ffff);
        ctrl_wr(32'h0010_0000);
        status_rd();
        `CHECK(st[1:0], 2'b01)
        `CHECK(waitrequest_out, 1'b1)
        ctrl_wr(32'h0000_0010);
        wait_idle();
        `CHECK(st[4], 1'b1)
        `CHECK({erase_cnt, erase_page}, {8'h1, 1'b0})
        ctrl_wr(32'h008f_ffff);
        ctrl_wr(32'h0090_0000);
        wait_idle();
        `CHECK(st[4], 1'b0)
        `CHECK(erase_cnt, 8'h1)
        ctrl_wr(32'h0000_0010);
        wait_idle();
        `CHECK({st[4], erase_cnt, erase_page}, {1'b1, 8'h2, 1'b1})
        ctrl_wr(32'h0000_5000);
        wait_idle();
        `CHECK(st[4], 1'b0)
        ctrl_wr(32'h0010_0000);
        wait_idle();
        ctrl_wr(32'h0060_0000);
        wait_idle();
        `CHECK(st[4], 1'b0)
        ctrl_wr(32'h0f8f_ffff);
        $display("erase tests done");
        data_rd(16'h0010, 8'h1, 1);
        `CHECK(got[0], fdata(16'h0010))
        status_rd();
        `CHECK(st[2], 1'b1)
        fork
            data_rd(16'h0000, 8'h80, 128);
            begin
                repeat (6) @(posedge ref_clk_in);
                status_rd();
                `CHECK(st[1:0], 2'b11)
            end
        join
        for (int i = 0; i < 128; i++) `CHECK(got[i], fdata(16'(i)))
        data_rd(16'h4ffe, 8'h3, 3);
        `CHECK(got[2], 32'hffffffff)
        status_rd();
        `CHECK(st[5:2], 4'b1000)
        data_rd(16'h0000, 8'h81, 1);
        status_rd();
        `CHECK(st[2], 1'b0)
        $display("incrementing read tests done");
        wrap_mode_in <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            wide_wrap_in <= (wn[k] == 3'd4);
            data_rd(wa[k], 8'(wn[k]), int'(wn[k]));
            b = wa[k] & ~16'(wn[k] - 3'd1);
            for (int i = 0; i < int'(wn[k]); i++)
                `CHECK(got[i], fdata(b | ((wa[k] + 16'(i)) & 16'(wn[k] - 3'd1))))
        end
        wrap_mode_in <= 1'b0;
        $display("wrapping read tests done");
        sect_protect_in <= 5'h02;
        data_rd(16'h1004, 8'h1, 1);
        `CHECK(got[0], 32'hffffffff)
        status_rd();
        `CHECK({st[10:6], st[2]}, {5'h02, 1'b0})
        sect_protect_in <= 5'h00;
        serial_mode_in <= 1'b1;
        data_rd(16'h0123, 8'h20, 32);
        w = fdata(16'h0123);
        for (int i = 0; i < 32; i++)
            `CHECK(got[i], {31'h0, w[31 - i]})
        $display("protected and serial read tests done");
        serial_mode_in <= 1'b0;
        ctrl_wr(32'h000f_ffff);
        fork
            data_wr(16'h0040, 32'h1234_5678);
            begin
                @(posedge ref_clk_in);
                status_rd();
                `CHECK(st[1:0], 2'b10)
            end
        join
        status_rd();
        `CHECK({st[3], prog_data}, {1'b1, 32'h1234_5678})
        $display("program tests done");
        report_and_stop();
    end
endmodule
`default_nettype wire
